/* File: core/vp_mode_pkg.sv */
// Constants and types shared by the video port mode control and status block
package vp_mode_pkg;

  localparam logic [7:0] ADDR_PORT_MODE_CONTROL = 8'h00;
  localparam logic [7:0] ADDR_PORT_CONDITION_STATUS = 8'h04;

  localparam int CTL_DUAL_BIT = 0;
  localparam int CTL_DISPLAY_BIT = 1;
  localparam int CTL_TRANSPORT_BIT = 2;
  localparam int CTL_POL1_BIT = 4;
  localparam int CTL_POL2_BIT = 5;
  localparam int CTL_HALT_BIT = 14;
  localparam int CTL_SOFT_RESET_BIT = 15;
  localparam int STAT_UPPER_HALF_BIT = 2;
  localparam int STAT_DUAL_DISABLE_BIT = 3;

  localparam logic RESET_HALT = 1'b1;
  localparam logic RESET_MODE_BIT = 1'b0;
  localparam logic RESET_POLARITY = 1'b0;

  localparam logic [7:0] SOFT_RESET_CYCLES = 8'h04;

  typedef enum logic [3:0] {
    MODE_SINGLE_CAPTURE = 4'h1,
    MODE_DUAL_CAPTURE = 4'h2,
    MODE_DISPLAY = 4'h4,
    MODE_TRANSPORT = 4'h8
  } port_mode_t;

  typedef enum logic [1:0] {
    SR_IDLE = 2'h1,
    SR_BUSY = 2'h2
  } soft_reset_state_t;

endpackage : vp_mode_pkg

/* File: core/vp_pin_sync.sv */
// Three-stage synchroniser with agreement filter for pin and strap inputs
module vp_pin_sync #(
  parameter int WIDTH = 4
) (
  input wire logic CLK,
  input wire logic RESET,
  input wire logic [WIDTH-1:0] async_in,
  output logic [WIDTH-1:0] sync_out
);

  typedef struct packed {
    logic [WIDTH-1:0] s1;
    logic [WIDTH-1:0] s2;
    logic [WIDTH-1:0] s3;
    logic [WIDTH-1:0] out;
  } sync_state_t;

  sync_state_t q;
  sync_state_t d;

  always_comb begin
    d = q;
    d.s1 = async_in;
    d.s2 = q.s1;
    d.s3 = q.s2;
    // Take a new level only once the second and third stage agree
    d.out = (q.s2 & q.s3) | (q.out & (q.s2 | q.s3));
  end

  always_ff @(posedge CLK or posedge RESET) begin
    if (RESET) begin
      q <= '0;
    end else begin
      q <= d;
    end
  end

  assign sync_out = q.out;

endmodule : vp_pin_sync

/* File: core/vp_mode_ctrl.sv */
// Video port mode control and status registers with Wishbone slave
//
// The implementer's own choices: the Wishbone interface to the registers and the register addresses.
module vp_mode_ctrl #(
  parameter logic [7:0] SOFT_RESET_CYCLES = vp_mode_pkg::SOFT_RESET_CYCLES
) (
  input wire logic CLK,
  input wire logic RESET,
  input wire logic WB_CYC_I,
  input wire logic WB_STB_I,
  input wire logic WB_WE_I,
  input wire logic [7:0] WB_ADR_I,
  input wire logic [3:0] WB_SEL_I,
  input wire logic [31:0] WB_DAT_I,
  output logic [31:0] WB_DAT_O,
  output logic WB_ACK_O,
  input wire logic CFG_DUAL_CHANNEL_DISABLE,
  input wire logic CFG_UPPER_BUS_HALF,
  input wire logic [1:0] CTRL_PIN_I,
  output logic [1:0] CTRL_PIN_O,
  output logic [1:0] CTRL_PIN_OE,
  output logic [1:0] CTRL_ACTIVE_IN,
  input wire logic [1:0] CTRL_ACTIVE_OUT,
  input wire logic [1:0] CTRL_DRIVE_EN,
  input wire logic [1:0] GPIO_MODE,
  input wire logic [1:0] GPIO_OUT,
  input wire logic [1:0] GPIO_OE,
  output logic [1:0] GPIO_IN,
  output logic [3:0] OPERATING_MODE,
  output logic DATA_PINS_OUT_EN,
  output logic CLK2_IS_OUTPUT,
  output logic FIFO_FLUSH,
  output logic PORT_HALTED
);

  typedef struct packed {
    logic ack;
    logic [31:0] rdata;
    vp_mode_pkg::soft_reset_state_t sr;
    logic [7:0] sr_cnt;
    logic halt;
    logic pol2;
    logic pol1;
    logic transport;
    logic display;
    logic dual;
    logic [1:0] pin_o;
    logic [1:0] pin_oe;
  } ctrl_state_t;

  localparam ctrl_state_t STATE_RESET = '{
    ack: 1'b0,
    rdata: 32'h0,
    sr: vp_mode_pkg::SR_IDLE,
    sr_cnt: 8'h00,
    halt: vp_mode_pkg::RESET_HALT,
    pol2: vp_mode_pkg::RESET_POLARITY,
    pol1: vp_mode_pkg::RESET_POLARITY,
    transport: vp_mode_pkg::RESET_MODE_BIT,
    display: vp_mode_pkg::RESET_MODE_BIT,
    dual: vp_mode_pkg::RESET_MODE_BIT,
    pin_o: 2'h0,
    pin_oe: 2'h0
  };

  ctrl_state_t q;
  ctrl_state_t d;

  logic [3:0] sync_q;
  logic dual_disable;
  logic upper_half;
  logic busy;
  logic hit;
  logic wr_ctl;
  logic [1:0] pol;
  logic [1:0] pin_o_d;
  logic [1:0] pin_oe_d;
  logic [31:0] ctl_rd;
  logic [31:0] stat_rd;
  vp_mode_pkg::port_mode_t mode;

  // Straps share the pin synchroniser; they may change after reset in a test
  vp_pin_sync #(
    .WIDTH(4)
  ) u_sync (
    .CLK(CLK),
    .RESET(RESET),
    .async_in({CFG_UPPER_BUS_HALF, CFG_DUAL_CHANNEL_DISABLE, CTRL_PIN_I}),
    .sync_out(sync_q)
  );

  assign dual_disable = sync_q[2];
  // Bus-half only reported, never steers the port
  assign upper_half = sync_q[3] & dual_disable;
  assign busy = (q.sr == vp_mode_pkg::SR_BUSY);
  assign pol = {q.pol2, q.pol1};
  assign GPIO_IN = sync_q[1:0];

  genvar gi;
  generate
    for (gi = 0; gi < 2; gi++) begin : g_pin
      assign CTRL_ACTIVE_IN[gi] = sync_q[gi] ^ pol[gi];
      // GPIO path bypasses polarity entirely
      assign pin_o_d[gi] = GPIO_MODE[gi] ? GPIO_OUT[gi] : (CTRL_ACTIVE_OUT[gi] ^ pol[gi]);
      assign pin_oe_d[gi] = busy ? 1'b0 : (GPIO_MODE[gi] ? GPIO_OE[gi] : CTRL_DRIVE_EN[gi]);
    end
  endgenerate

  always_comb begin
    if (q.transport) begin
      mode = vp_mode_pkg::MODE_TRANSPORT;
    end else if (q.display) begin
      mode = vp_mode_pkg::MODE_DISPLAY;
    end else if (q.dual) begin
      mode = vp_mode_pkg::MODE_DUAL_CAPTURE;
    end else begin
      mode = vp_mode_pkg::MODE_SINGLE_CAPTURE;
    end
  end

  always_comb begin
    ctl_rd = 32'h0;
    ctl_rd[vp_mode_pkg::CTL_SOFT_RESET_BIT] = busy;
    ctl_rd[vp_mode_pkg::CTL_HALT_BIT] = q.halt;
    ctl_rd[vp_mode_pkg::CTL_POL2_BIT] = q.pol2;
    ctl_rd[vp_mode_pkg::CTL_POL1_BIT] = q.pol1;
    ctl_rd[vp_mode_pkg::CTL_TRANSPORT_BIT] = q.transport;
    ctl_rd[vp_mode_pkg::CTL_DISPLAY_BIT] = q.display;
    ctl_rd[vp_mode_pkg::CTL_DUAL_BIT] = q.dual;
    stat_rd = 32'h0;
    stat_rd[vp_mode_pkg::STAT_DUAL_DISABLE_BIT] = dual_disable;
    stat_rd[vp_mode_pkg::STAT_UPPER_HALF_BIT] = upper_half;
  end

  assign hit = WB_CYC_I & WB_STB_I;
  assign wr_ctl = hit & q.ack & WB_WE_I & (WB_ADR_I == vp_mode_pkg::ADDR_PORT_MODE_CONTROL);

  always_comb begin
    d = q;
    d.ack = hit & ~q.ack;
    if (hit & ~q.ack) begin
      if (WB_ADR_I == vp_mode_pkg::ADDR_PORT_MODE_CONTROL) begin
        d.rdata = ctl_rd;
      end else if (WB_ADR_I == vp_mode_pkg::ADDR_PORT_CONDITION_STATUS) begin
        d.rdata = stat_rd;
      end else begin
        d.rdata = 32'h0;
      end
    end
    case (q.sr)
      vp_mode_pkg::SR_IDLE: begin
        if (wr_ctl & WB_SEL_I[1]) begin
          if (WB_DAT_I[vp_mode_pkg::CTL_HALT_BIT]) begin
            d.halt = 1'b0;
          end
          if (WB_DAT_I[vp_mode_pkg::CTL_SOFT_RESET_BIT]) begin
            d.sr = vp_mode_pkg::SR_BUSY;
            d.sr_cnt = SOFT_RESET_CYCLES - 8'h01;
          end
        end
        // Bus writes move mode and polarity only while halted
        if (wr_ctl & WB_SEL_I[0] & q.halt) begin
          d.pol2 = WB_DAT_I[vp_mode_pkg::CTL_POL2_BIT];
          d.pol1 = WB_DAT_I[vp_mode_pkg::CTL_POL1_BIT];
          d.transport = WB_DAT_I[vp_mode_pkg::CTL_TRANSPORT_BIT];
          d.display = WB_DAT_I[vp_mode_pkg::CTL_DISPLAY_BIT];
          d.dual = WB_DAT_I[vp_mode_pkg::CTL_DUAL_BIT];
        end
      end
      vp_mode_pkg::SR_BUSY: begin
        // Bus writes are ignored until the port has settled
        d.sr_cnt = q.sr_cnt - 8'h01;
        if (q.sr_cnt == 8'h00) begin
          d.sr = vp_mode_pkg::SR_IDLE;
          d.halt = vp_mode_pkg::RESET_HALT;
          d.pol2 = vp_mode_pkg::RESET_POLARITY;
          d.pol1 = vp_mode_pkg::RESET_POLARITY;
          d.transport = vp_mode_pkg::RESET_MODE_BIT;
          d.display = vp_mode_pkg::RESET_MODE_BIT;
          d.dual = vp_mode_pkg::RESET_MODE_BIT;
        end
      end
      default: begin
        d.sr = vp_mode_pkg::SR_IDLE;
      end
    endcase
    if (dual_disable) begin
      d.dual = 1'b0;
    end
    d.pin_o = pin_o_d;
    d.pin_oe = pin_oe_d;
  end

  always_ff @(posedge CLK or posedge RESET) begin
    if (RESET) begin
      q <= STATE_RESET;
    end else begin
      q <= d;
    end
  end

  assign WB_ACK_O = q.ack;
  assign WB_DAT_O = q.rdata;
  assign CTRL_PIN_O = q.pin_o;
  assign CTRL_PIN_OE = q.pin_oe;
  assign OPERATING_MODE = mode;
  assign DATA_PINS_OUT_EN = (mode == vp_mode_pkg::MODE_DISPLAY) & ~busy;
  assign CLK2_IS_OUTPUT = (mode == vp_mode_pkg::MODE_DISPLAY) & ~busy;
  assign FIFO_FLUSH = busy;
  assign PORT_HALTED = q.halt;

  default clocking cb @(posedge CLK);
  endclocking
  default disable iff (RESET);

  property p_dual_forced;
    q.dual |-> ##1 (!dual_disable || !$past(dual_disable) || !q.dual);
  endproperty
  a_dual_forced: assert property (p_dual_forced) else $error("dual bit kept under dual disable");

  property p_dual_clear;
    dual_disable |=> !q.dual;
  endproperty
  a_dual_clear: assert property (p_dual_clear) else $error("dual bit not forced to zero");

  property p_upper_half;
    WB_ACK_O && $past(WB_ADR_I) == vp_mode_pkg::ADDR_PORT_CONDITION_STATUS
      && WB_DAT_O[vp_mode_pkg::STAT_UPPER_HALF_BIT]
      |-> $past(dual_disable);
  endproperty
  a_upper_half: assert property (p_upper_half) else $error("bus half set without disable");

  property p_status_rsvd;
    WB_ACK_O && $past(WB_ADR_I) == vp_mode_pkg::ADDR_PORT_CONDITION_STATUS
      |-> WB_DAT_O[31:4] == 28'h0 && WB_DAT_O[1:0] == 2'h0;
  endproperty
  a_status_rsvd: assert property (p_status_rsvd) else $error("status reserved bits nonzero");

  property p_ctl_rsvd;
    WB_ACK_O && $past(WB_ADR_I) == vp_mode_pkg::ADDR_PORT_MODE_CONTROL
      |-> WB_DAT_O[3] == 1'b0 && WB_DAT_O[13:6] == 8'h0 && WB_DAT_O[31:16] == 16'h0;
  endproperty
  a_ctl_rsvd: assert property (p_ctl_rsvd) else $error("control reserved bits nonzero");

  property p_halt_lock;
    !q.halt && !busy |=> $stable(q.pol1) && $stable(q.pol2) && $stable(q.transport)
      && $stable(q.display);
  endproperty
  a_halt_lock: assert property (p_halt_lock) else $error("control changed while running");

  property p_soft_reset_ends;
    $rose(busy) |-> ##[1:300] !busy;
  endproperty
  a_soft_reset_ends: assert property (p_soft_reset_ends) else $error("soft reset stuck");

  property p_soft_reset_result;
    $fell(busy) |-> q.halt && !q.transport && !q.display && !q.pol1 && !q.pol2
      && CTRL_PIN_OE == 2'h0;
  endproperty
  a_soft_reset_result: assert property (p_soft_reset_result) else $error("bad soft reset");

  property p_pol_out;
    !GPIO_MODE[0] |=> CTRL_PIN_O[0] == ($past(CTRL_ACTIVE_OUT[0]) ^ $past(q.pol1));
  endproperty
  a_pol_out: assert property (p_pol_out) else $error("pin 1 polarity wrong");

  property p_pol2_in;
    CTRL_ACTIVE_IN[1] == (sync_q[1] ^ q.pol2);
  endproperty
  a_pol2_in: assert property (p_pol2_in) else $error("pin 2 polarity wrong");

  property p_gpio_raw;
    GPIO_MODE[1] |=> CTRL_PIN_O[1] == $past(GPIO_OUT[1]);
  endproperty
  a_gpio_raw: assert property (p_gpio_raw) else $error("gpio output altered");

  property p_mode_decode;
    (q.transport |-> mode == vp_mode_pkg::MODE_TRANSPORT)
      and (!q.transport && q.display |-> mode == vp_mode_pkg::MODE_DISPLAY)
      and (!q.transport && !q.display && !q.dual |-> mode == vp_mode_pkg::MODE_SINGLE_CAPTURE);
  endproperty
  a_mode_decode: assert property (p_mode_decode) else $error("mode decode wrong");

  property p_display_pins;
    mode == vp_mode_pkg::MODE_DISPLAY && !busy |-> DATA_PINS_OUT_EN && CLK2_IS_OUTPUT;
  endproperty
  a_display_pins: assert property (p_display_pins) else $error("display pins not driven");

  // Forcing lags the strap by one cycle, so look at the cycle before
  property p_dual_mode;
    !q.transport && !q.display && q.dual |-> mode == vp_mode_pkg::MODE_DUAL_CAPTURE
      && !$past(dual_disable);
  endproperty
  a_dual_mode: assert property (p_dual_mode) else $error("dual capture mode wrong");

  property p_status_dual;
    WB_ACK_O && $past(WB_ADR_I) == vp_mode_pkg::ADDR_PORT_CONDITION_STATUS
      |-> WB_DAT_O[vp_mode_pkg::STAT_DUAL_DISABLE_BIT] == $past(dual_disable);
  endproperty
  a_status_dual: assert property (p_status_dual) else $error("dual disable not reported");

  c_soft_reset: cover property ($rose(busy) ##[1:20] $fell(busy));
  c_dual: cover property (mode == vp_mode_pkg::MODE_DUAL_CAPTURE);
  c_display: cover property (mode == vp_mode_pkg::MODE_DISPLAY && !q.halt);
  c_transport: cover property (mode == vp_mode_pkg::MODE_TRANSPORT);

endmodule : vp_mode_ctrl

/* File: verif/vp_pin_partner.sv */
// Far-side model of the two video control pins with pull-ups
module vp_pin_partner (
  input wire logic [1:0] pin_o,
  input wire logic [1:0] pin_oe,
  input wire logic [1:0] ext_val,
  input wire logic [1:0] ext_en,
  output logic [1:0] pin_level
);
  timeunit 1ns;
  timeprecision 1ns;
  // External source yields while the port drives; undriven pins float high
  always_comb begin
    for (int i = 0; i < 2; i++) begin
      pin_level[i] = pin_oe[i] ? pin_o[i] : (ext_en[i] ? ext_val[i] : 1'b1);
    end
  end
endmodule : vp_pin_partner

/* File: verif/tb_top.sv */
// Self-checking bench for the video port mode control and status block
module tb_top;
  timeunit 1ns;
  timeprecision 1ns;
  logic CLK, RESET, cyc, stb, we, dual_channel_disable, upper_bus_half_in_use, ack, flush, halted, dpo, c2o;
  logic [7:0] adr;
  logic [3:0] sel, opmode;
  logic [31:0] wdat, rdo, rd, val;
  logic [1:0] pin_i, pin_o, pin_oe, act_in, act_out, drv_en, gmode, gout, goe, gin, ev, ee;
  logic [1:0] eo, eoe, lvl;
  logic [5:0] ctl;
  logic [31:0] corner [3] = '{32'h00030001, 32'h0000003f, 32'h00000001};
  int num_errors = 0;
  int check_count = 0;
  int seed = 78686;

  vp_mode_ctrl #(.SOFT_RESET_CYCLES(8'h04)) u_vp_mode_ctrl (
    .CLK(CLK), .RESET(RESET), .WB_CYC_I(cyc), .WB_STB_I(stb), .WB_WE_I(we),
    .WB_ADR_I(adr), .WB_SEL_I(sel), .WB_DAT_I(wdat), .WB_DAT_O(rdo), .WB_ACK_O(ack),
    .CFG_DUAL_CHANNEL_DISABLE(dual_channel_disable), .CFG_UPPER_BUS_HALF(upper_bus_half_in_use), .CTRL_PIN_I(pin_i),
    .CTRL_PIN_O(pin_o), .CTRL_PIN_OE(pin_oe), .CTRL_ACTIVE_IN(act_in),
    .CTRL_ACTIVE_OUT(act_out), .CTRL_DRIVE_EN(drv_en), .GPIO_MODE(gmode), .GPIO_OUT(gout),
    .GPIO_OE(goe), .GPIO_IN(gin), .OPERATING_MODE(opmode), .DATA_PINS_OUT_EN(dpo),
    .CLK2_IS_OUTPUT(c2o), .FIFO_FLUSH(flush), .PORT_HALTED(halted));

  vp_pin_partner u_vp_pin_partner (.pin_o(pin_o), .pin_oe(pin_oe), .ext_val(ev),
    .ext_en(ee), .pin_level(pin_i));

  task automatic wrap_up();
    if (num_errors == 0 && check_count > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask : wrap_up

  task automatic chk_reg(input logic [31:0] exp, input logic [31:0] got);
    check_count++;
    if (got !== exp) begin
      num_errors++;
      $display("MISMATCH t=%0t exp=%h got=%h", $time, exp, got);
    end
  endtask : chk_reg

  task automatic chk_sig(input logic [3:0] exp, input logic [3:0] got);
    check_count++;
    if (got !== exp) begin
      num_errors++;
      $display("MISMATCH t=%0t exp=%h got=%h", $time, exp, got);
    end
  endtask : chk_sig

  // Classic single cycle; request held until ack is sampled high
  task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d,
                    input logic [3:0] s);
    int n;
    n = 0;
    cyc <= 1'b1;
    stb <= 1'b1;
    we <= w;
    adr <= a;
    wdat <= d;
    sel <= s;
    do begin
      @(posedge CLK);
      n++;
    end while (ack !== 1'b1 && n < 50);
    if (ack !== 1'b1) begin
      num_errors++;
      wrap_up();
    end
    rd = rdo;
    cyc <= 1'b0;
    stb <= 1'b0;
    we <= 1'b0;
    @(posedge CLK);
  endtask : wb

  function automatic logic [3:0] exp_mode(input logic [2:0] m, input logic dcd);
    if (m[2]) return 4'h8;
    if (m[1]) return 4'h4;
    if (m[0] && !dcd) return 4'h2;
    return 4'h1;
  endfunction : exp_mode

  task automatic pin_check(input logic [1:0] pol);
    val = $random(seed);
    {ev, ee, gmode, gout, goe, act_out, drv_en} <= val[13:0];
    // Room for output register plus synchroniser and agreement filter
    repeat (6) @(posedge CLK);
    eo = (gmode & gout) | (~gmode & (act_out ^ pol));
    eoe = (gmode & goe) | (~gmode & drv_en);
    lvl = (eoe & eo) | (~eoe & (~ee | ev));
    chk_sig({eoe, eo}, {pin_oe, pin_o});
    chk_sig({2'b00, lvl}, {2'b00, gin});
    chk_sig({2'b00, (lvl ^ pol) & ~gmode}, {2'b00, act_in & ~gmode});
  endtask : pin_check

  initial begin
    CLK = 1'b0;
    forever #25 CLK = ~CLK;
  end

  initial begin
    repeat (20000) @(posedge CLK);
    num_errors++;
    wrap_up();
  end

  initial begin
    RESET = 1'b1;
    {cyc, stb, we, dual_channel_disable, upper_bus_half_in_use, adr, sel, wdat} = '0;
    {act_out, drv_en, gmode, gout, goe, ev, ee} = '0;
    repeat (12) @(posedge CLK);
    RESET <= 1'b0;
    repeat (4) @(posedge CLK);
    wb(1'b0, 8'h00, 32'h0, 4'hf);
    chk_reg(32'h00004000, rd);
    chk_sig(4'h1, opmode);
    for (int k = 0; k < 12; k++) begin
      val = (k < 3) ? corner[k] : $random(seed);
      dual_channel_disable <= val[16];
      upper_bus_half_in_use <= val[17];
      repeat (6) @(posedge CLK);
      wb(1'b1, 8'h04, val, 4'hf);
      wb(1'b0, 8'h04, 32'h0, 4'hf);
      chk_reg({28'h0, dual_channel_disable, upper_bus_half_in_use & dual_channel_disable, 2'b00}, rd);
      wb(1'b1, 8'h00, val & 32'hffff3fff, 4'hf);
      ctl = val[5:0] & 6'h37;
      ctl[0] = ctl[0] & ~dual_channel_disable;
      wb(1'b0, 8'h00, 32'h0, 4'hf);
      chk_reg({16'h0, 2'b01, 8'h0, ctl}, rd);
      chk_sig(exp_mode(ctl[2:0], dual_channel_disable), opmode);
      chk_sig({2'b00, {2{exp_mode(ctl[2:0], dual_channel_disable) == 4'h4}}}, {2'b00, dpo, c2o});
      pin_check(ctl[5:4]);
    end
    // Lane 0 disabled: mode and polarity bits must hold
    wb(1'b1, 8'h00, {26'h0, ~ctl}, 4'h2);
    wb(1'b0, 8'h00, 32'h0, 4'hf);
    chk_reg({16'h0, 2'b01, 8'h0, ctl}, rd);
    wb(1'b1, 8'h08, 32'hffffffff, 4'hf);
    wb(1'b0, 8'h08, 32'h0, 4'hf);
    chk_reg(32'h0, rd);
    // Upper lane only, so the halt clear leaves the mode bits alone
    wb(1'b1, 8'h00, 32'h00004000, 4'h2);
    chk_sig(4'h0, {3'b000, halted});
    wb(1'b1, 8'h00, {26'h0, ~ctl} & 32'h37, 4'hf);
    wb(1'b0, 8'h00, 32'h0, 4'hf);
    chk_reg({26'h0, ctl}, rd);
    drv_en <= 2'b11;
    gmode <= 2'b00;
    wb(1'b1, 8'h00, 32'h00008000, 4'hf);
    // Enables are registered one cycle behind the busy state
    @(posedge CLK);
    chk_sig(4'h4, {1'b0, flush, pin_oe});
    rd = 32'h00008000;
    for (int n = 0; n < 20 && rd[15] !== 1'b0; n++) begin
      wb(1'b0, 8'h00, 32'h0, 4'hf);
    end
    chk_reg(32'h00004000, rd);
    chk_sig(4'h1, opmode);
    wrap_up();
  end
endmodule : tb_top
